// ==== dv/dadc_conv_model.sv ====
`timescale 1ns/1ps
module dadc_conv_model (
    input wire logic mclk, // System clock
    input wire logic nrst, // Synchronous reset, low
    input wire logic unit_sampling, // Sample window
    input wire logic [2:0] unit_one_input_select, // Unit one mux code
    input wire logic [2:0] unit_two_input_select, // Unit two mux code
    output logic [9:0] unit_one_data, // Unit one result
    output logic [9:0] unit_two_data, // Unit two result
    output logic [7:0] samples, // Sample windows seen
    output logic [7:0] samp_len // Length of last window
);
    logic [7:0] run;
    logic prev;
    // Result tags the mux code and window count so stale data shows up
    always @(posedge mclk) begin
        prev <= unit_sampling;
        if (!nrst) begin
            samples <= 8'h00;
            run <= 8'h00;
            samp_len <= 8'h00;
            unit_one_data <= 10'h000;
            unit_two_data <= 10'h000;
        end else begin
            if (unit_sampling && !prev) begin
                samples <= samples + 8'h01;
                unit_one_data <= {unit_one_input_select, 7'(samples + 8'h01)};
                unit_two_data <= {unit_two_input_select, 7'(samples + 8'h01)};
            end
            if (unit_sampling) begin
                run <= run + 8'h01;
            end else if (prev) begin
                samp_len <= run;
                run <= 8'h00;
            end
        end
    end
endmodule : dadc_conv_model

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
    import dadc_pkg::*;
;
    logic mclk, nrst, avs_read, avs_write, avs_waitrequest, ev_compare_match, pin_start_pulse;
    logic unit_one_active, unit_two_active, unit_sampling, irq_request, emu_suspend;
    logic [ADDR_W-1:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [9:0] d1, d2;
    logic [2:0] s1, s2;
    logic [7:0] samples, samp_len, c0;
    logic [15:0] q;
    int num_errors, total_checks, cycles, n;

    dadc_ctrl i_dadc_ctrl (.mclk(mclk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ev_compare_match(ev_compare_match),
        .pin_start_pulse(pin_start_pulse), .emu_suspend(emu_suspend), .unit_one_data(d1), .unit_two_data(d2),
        .unit_one_input_select(s1), .unit_two_input_select(s2), .unit_one_active(unit_one_active),
        .unit_two_active(unit_two_active), .unit_sampling(unit_sampling), .irq_request(irq_request));
    dadc_conv_model i_dadc_conv_model (.mclk(mclk), .nrst(nrst), .unit_sampling(unit_sampling),
        .unit_one_input_select(s1), .unit_two_input_select(s2), .unit_one_data(d1), .unit_two_data(d2),
        .samples(samples), .samp_len(samp_len));

    always #2.5 mclk = ~mclk;

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    // Whole run needs well under this
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
            num_errors++;
        end
    endtask : chk

    // Holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [15:0] d);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {16'h0000, d};
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[15:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask : bus

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
        bus(1'b0, a, 16'h0000);
        chk(q, exp);
    endtask : rd_chk

    task automatic wait_idle();
        do bus(1'b0, ADDR_CTRL_ONE, 16'h0000); while (q[B_CONV_ACT] !== 1'b0);
    endtask : wait_idle

    task automatic run_conv(input logic [15:0] c1);
        bus(1'b1, ADDR_CTRL_ONE, c1);
        n++;
        bus(1'b0, ADDR_CTRL_ONE, 16'h0000);
        chk(q[B_CONV_ACT], 1'b1);
        wait_idle();
    endtask : run_conv

    // Trigger held three cycles, short of the pin repeat length
    task automatic fire(input logic pin);
        pin_start_pulse <= pin;
        ev_compare_match <= !pin;
        repeat (3) @(posedge mclk);
        pin_start_pulse <= 1'b0;
        ev_compare_match <= 1'b0;
        bus(1'b0, ADDR_CTRL_ONE, 16'h0000);
    endtask : fire

    task automatic t_reset();
        rd_chk(ADDR_CTRL_ONE, 16'h0000);
        rd_chk(ADDR_CTRL_TWO, 16'h0000);
        rd_chk(ADDR_RESULT_ONE, 16'h0000);
        rd_chk(ADDR_RESULT_TWO, 16'h0000);
        rd_chk(18'h00010, 16'h0000);
        bus(1'b1, ADDR_CTRL_TWO, 16'hFFFF);
        rd_chk(ADDR_CTRL_TWO, 16'h0607);
        bus(1'b1, ADDR_CTRL_TWO, 16'h0000);
    endtask : t_reset

    task automatic t_single();
        run_conv(16'h182B);
        chk(s1, 3'h5);
        chk(s2, 3'h2);
        chk({unit_one_active, unit_two_active}, 2'h3);
        rd_chk(ADDR_CTRL_TWO, 16'h0048);
        rd_chk(ADDR_RESULT_ONE, {3'h5, 7'(n), 6'h00});
        rd_chk(ADDR_CTRL_TWO, 16'h0008);
        rd_chk(ADDR_RESULT_TWO, {3'h2, 7'(n), 6'h00});
    endtask : t_single

    task automatic t_overflow();
        repeat (3) run_conv(16'h100B);
        rd_chk(ADDR_CTRL_TWO, 16'h00C0);
        rd_chk(ADDR_RESULT_ONE, {3'h5, 7'(n - 1), 6'h00});
        rd_chk(ADDR_CTRL_TWO, 16'h0040);
        rd_chk(ADDR_RESULT_ONE, {3'h5, 7'(n), 6'h00});
        rd_chk(ADDR_CTRL_TWO, 16'h0000);
    endtask : t_overflow

    task automatic t_flag_irq();
        bus(1'b1, ADDR_CTRL_ONE, 16'h1000);
        bus(1'b0, ADDR_CTRL_ONE, 16'h0000);
        chk(q[B_IRQ_FLAG], 1'b1);
        bus(1'b1, ADDR_CTRL_ONE, 16'h0100);
        bus(1'b0, ADDR_CTRL_ONE, 16'h0000);
        chk(q[B_IRQ_FLAG], 1'b0);
        run_conv(16'h1201);
        repeat (2) @(posedge mclk);
        chk(irq_request, 1'b1);
        bus(1'b1, ADDR_CTRL_ONE, 16'h1300);
        repeat (2) @(posedge mclk);
        chk(irq_request, 1'b0);
        rd_chk(ADDR_RESULT_ONE, {3'h0, 7'(n), 6'h00});
    endtask : t_flag_irq

    task automatic t_triggers();
        bus(1'b1, ADDR_CTRL_ONE, 16'h0000);
        bus(1'b1, ADDR_CTRL_TWO, 16'h0400);
        fire(1'b0);
        chk(q[B_CONV_ACT], 1'b0);
        bus(1'b1, ADDR_CTRL_ONE, 16'h1000);
        bus(1'b1, ADDR_CTRL_TWO, 16'h0000);
        fire(1'b0);
        chk(q[B_CONV_ACT], 1'b0);
        bus(1'b1, ADDR_CTRL_TWO, 16'h0400);
        fire(1'b0);
        chk(q[B_CONV_ACT], 1'b1);
        wait_idle();
        bus(1'b1, ADDR_CTRL_TWO, 16'h0200);
        fire(1'b1);
        chk(q[B_CONV_ACT], 1'b1);
        wait_idle();
        rd_chk(ADDR_CTRL_TWO, 16'h0280);
        bus(1'b1, ADDR_CTRL_TWO, 16'h0000);
        run_conv(16'h3000);
    endtask : t_triggers

    task automatic t_divider();
        logic [2:0] codes[3] = '{3'h0, 3'h3, 3'h7};
        logic [7:0] lens[3] = '{8'h04, 8'h0A, 8'h20};
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, ADDR_CTRL_TWO, {13'h0000, codes[i]});
            run_conv(16'h1001);
            chk(samp_len, lens[i]);
        end
        bus(1'b1, ADDR_CTRL_TWO, 16'h0000);
    endtask : t_divider

    task automatic t_continuous();
        c0 = samples;
        bus(1'b1, ADDR_CTRL_ONE, 16'h1401);
        repeat (100) @(posedge mclk);
        chk(8'(samples - c0) >= 8'h03, 1'b1);
        bus(1'b1, ADDR_CTRL_ONE, 16'h1000);
        // Busy drops for one cycle before the last rerun; poll past that gap
        repeat (2) wait_idle();
        c0 = samples;
        repeat (60) @(posedge mclk);
        chk(samples, c0);
    endtask : t_continuous

    // Soft clear freezes a running conversion; free bit lets a start through
    task automatic t_suspend();
        bus(1'b1, ADDR_CTRL_ONE, 16'h1001);
        emu_suspend <= 1'b1;
        repeat (60) @(posedge mclk);
        bus(1'b0, ADDR_CTRL_ONE, 16'h0000);
        chk(q[B_CONV_ACT], 1'b1);
        emu_suspend <= 1'b0;
        wait_idle();
        emu_suspend <= 1'b1;
        bus(1'b1, ADDR_CTRL_ONE, 16'h1001);
        bus(1'b0, ADDR_CTRL_ONE, 16'h0000);
        chk(q[B_CONV_ACT], 1'b0);
        bus(1'b1, ADDR_CTRL_ONE, 16'h5001);
        bus(1'b0, ADDR_CTRL_ONE, 16'h0000);
        chk(q[B_CONV_ACT], 1'b1);
        emu_suspend <= 1'b0;
    endtask : t_suspend

    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        ev_compare_match = 1'b0;
        pin_start_pulse = 1'b0;
        emu_suspend = 1'b0;
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_single();
        t_overflow();
        t_flag_irq();
        t_triggers();
        t_divider();
        t_continuous();
        t_suspend();
        end_sim();
    end
endmodule : tb_top

// ==== verilog/dadc_conv_if.sv ====
`timescale 1ns/1ps
interface dadc_conv_if;
    logic start;
    logic hold;
    logic [2:0] div_code;
    logic sampling;
    logic done;
    modport ctrl (output start, output hold, output div_code, input sampling, input done);
    modport timer (input start, input hold, input div_code, output sampling, output done);
endinterface : dadc_conv_if

// ==== verilog/dadc_conv_timer.sv ====
`timescale 1ns/1ps
module dadc_conv_timer
    import dadc_pkg::*;
(
    input wire logic mclk, // System clock
    input wire logic nrst, // Synchronous reset, low
    dadc_conv_if.timer cif // Conversion control
);

    typedef struct packed {
        dadc_phase_e phase;
        logic [5:0] cnt;
        logic [5:0] div;
        logic [2:0] ticks;
        logic done;
        logic sampling;
    } dadc_tmr_s;

    dadc_tmr_s st_reg;
    dadc_tmr_s st_next;

    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        if (cif.start) begin
            // Divisor latched so a mid-conversion change waits for the next one
            st_next.phase = PH_SAMPLE;
            st_next.cnt = 6'h00;
            st_next.ticks = 3'h0;
            st_next.div = divisor_of(cif.div_code);
        end else if (!cif.hold) begin // R12
            unique case (st_reg.phase)
                PH_IDLE: begin
                end
                PH_SAMPLE, PH_CONVERT: begin
                    if (st_reg.cnt == st_reg.div - 6'h01) begin
                        st_next.cnt = 6'h00;
                        st_next.ticks = st_reg.ticks + 3'h1;
                        if (st_reg.ticks == SAMPLE_TICKS - 3'h1) begin // R22
                            st_next.phase = PH_CONVERT;
                        end
                        if (st_reg.ticks == TOTAL_TICKS - 3'h1) begin // R22
                            st_next.phase = PH_IDLE;
                            st_next.done = 1'b1;
                        end
                    end else begin
                        st_next.cnt = st_reg.cnt + 6'h01;
                    end
                end
                default: st_next.phase = PH_IDLE;
            endcase
        end
        // Registered so the top-level pin comes straight from a flop
        st_next.sampling = (st_next.phase == PH_SAMPLE);
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cif.sampling = st_reg.sampling;
    assign cif.done = st_reg.done;

    AST_HOLD_FREEZES: assert property (@(posedge mclk) disable iff (!nrst) // R12
        (cif.hold && !cif.start && st_reg.phase != PH_IDLE) |=> $stable(st_reg.cnt) && !st_reg.done)
        else $error("timer moved while held");

endmodule : dadc_conv_timer

// ==== verilog/dadc_ctrl.sv ====
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
// Behaviour
// R1: Immediate-start write begins conversion at once
// R2: Disabled unit neither converts nor changes queue
// R3: Shadowed writes apply at next conversion start
// R4: Continuous bit repeats conversions back to back
// R5: Interrupt request when flag and enable set
// R6: Flag set by event, write one clears
// R7: Busy status reads one during conversion
// R8: Unit two select codes channels 9-16
// R9: Unit one select codes channels 1-8
// R10: Software start bit requests a conversion
// R11: No start without an enabled unit
// R12: Suspend: free runs, soft finishes, else halt
// R13: Compare-match start gated by its enable
// R14: Pin start gated by its enable
// R15: Pin held over seven clocks restarts once
// R16: Reserved control-two bits ignore writes
// R17: Unit one queue level: 0,1,2,lost
// R18: Unit two queue level, same encoding
// R19: Two-deep queue, third result drops oldest
// R20: Divider code selects 4 to 32
// R21: Result left aligned, low six bits zero
// R22: One sample plus five convert ticks
// R23: Every completion sets the interrupt flag
// R24: Result read pops oldest entry
// R25: Busy from any start until results written
module dadc_ctrl
    import dadc_pkg::*;
#(
    parameter int PIN_LONG_CYCLES = 7 // Pin high length to exceed for a repeat
)(
    input wire logic mclk, // System clock, 200 MHz
    input wire logic nrst, // Synchronous reset, low
    input wire logic [ADDR_W-1:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    input wire logic ev_compare_match, // Timer event unit compare pulse
    input wire logic pin_start_pulse, // External start pin level
    input wire logic emu_suspend, // Debugger suspend request
    input wire logic [RES_W-1:0] unit_one_data, // Unit one converter output
    input wire logic [RES_W-1:0] unit_two_data, // Unit two converter output
    output logic [2:0] unit_one_input_select, // Unit one mux code
    output logic [2:0] unit_two_input_select, // Unit two mux code
    output logic unit_one_active, // Unit one takes part
    output logic unit_two_active, // Unit two takes part
    output logic unit_sampling, // Sample-and-hold window
    output logic irq_request // Interrupt request
);

    if (PIN_LONG_CYCLES < 1 || PIN_LONG_CYCLES > 14) begin : g_bad_pin
        $error("PIN_LONG_CYCLES must lie in 1..14");
    end

    localparam logic [3:0] PIN_LONG = 4'(PIN_LONG_CYCLES);

    typedef struct packed {
        logic wreq;
        logic [31:0] rdata;
        logic irq;
        dadc_cfg_s sh;
        dadc_cfg_s act;
        logic susp_soft;
        logic susp_free;
        logic flag;
        logic [2:0] div_code;
        logic busy;
        logic imm;
        logic rerun;
        logic pin_pend;
        logic pin_prev;
        logic [3:0] pin_cnt;
        logic start;
        logic hold;
        dadc_fifo_s [1:0] fifo;
    } dadc_ctrl_s;

    dadc_ctrl_s st_reg;
    dadc_ctrl_s st_next;

    dadc_conv_if cif ();

    dadc_conv_timer u_timer (
        .mclk(mclk),
        .nrst(nrst),
        .cif(cif.timer)
    );

    logic req_first;
    logic wr_now;
    logic rd_now;
    logic conv_end;
    logic blocked;
    logic any_en;
    logic pin_rise;
    logic go;
    logic flag_clr;
    logic [1:0] push;
    logic [1:0] pop;
    logic [31:0] rd_word;

    always_comb begin
        st_next = st_reg;
        st_next.start = 1'b0;
        // Wait state on first cycle of every request; answer registered one edge later
        req_first = (avs_read || avs_write) && st_reg.wreq;
        wr_now = avs_write && !st_reg.wreq;
        rd_now = avs_read && req_first;
        st_next.wreq = !req_first;
        conv_end = st_reg.busy && cif.done;
        blocked = emu_suspend && !st_reg.susp_free; // R12
        any_en = st_reg.sh.en_one || st_reg.sh.en_two; // R11
        pin_rise = pin_start_pulse && !st_reg.pin_prev && st_reg.act.pin_trig; // R14
        flag_clr = 1'b0;
        push = 2'b00;
        pop = 2'b00;

        // Read mux; queue pops on the same edge that captures the word
        rd_word = 32'h0000_0000;
        unique case (avs_address)
            ADDR_CTRL_ONE: begin
                rd_word[B_SUSP_SOFT] = st_reg.susp_soft;
                rd_word[B_SUSP_FREE] = st_reg.susp_free;
                rd_word[B_EN_ONE] = st_reg.sh.en_one;
                rd_word[B_EN_TWO] = st_reg.sh.en_two;
                rd_word[B_CONT_RUN] = st_reg.sh.cont_run;
                rd_word[B_IRQ_EN] = st_reg.sh.irq_en;
                rd_word[B_IRQ_FLAG] = st_reg.flag;
                rd_word[B_CONV_ACT] = st_reg.busy; // R7
                rd_word[B_SEL_TWO +: 3] = st_reg.sh.sel_two;
                rd_word[B_SEL_ONE +: 3] = st_reg.sh.sel_one;
                rd_word[B_SW_START] = st_reg.sh.sw_start;
            end
            ADDR_CTRL_TWO: begin
                rd_word[B_CMP_TRIG] = st_reg.sh.cmp_trig;
                rd_word[B_PIN_TRIG] = st_reg.sh.pin_trig;
                rd_word[B_LVL_ONE +: 2] = fifo_level(st_reg.fifo[0]); // R17
                rd_word[B_LVL_TWO +: 2] = fifo_level(st_reg.fifo[1]); // R18
                rd_word[B_DIVIDER +: 3] = st_reg.div_code;
            end
            ADDR_RESULT_ONE: begin
                if (st_reg.fifo[0].count != 2'h0) begin
                    rd_word[B_RESULT +: RES_W] = st_reg.fifo[0].data[0]; // R21
                end
                pop[0] = rd_now; // R24
            end
            ADDR_RESULT_TWO: begin
                if (st_reg.fifo[1].count != 2'h0) begin
                    rd_word[B_RESULT +: RES_W] = st_reg.fifo[1].data[0]; // R21
                end
                pop[1] = rd_now; // R24
            end
            default: rd_word = 32'h0000_0000;
        endcase
        if (rd_now) begin
            st_next.rdata = rd_word;
        end

        // External pin: edge starts, a long level earns one more start
        st_next.pin_prev = pin_start_pulse;
        if (!pin_start_pulse) begin
            st_next.pin_cnt = 4'h0;
        end else if (st_reg.pin_cnt != PIN_LONG + 4'h1) begin
            st_next.pin_cnt = st_reg.pin_cnt + 4'h1;
        end
        if (pin_start_pulse && st_reg.pin_cnt == PIN_LONG && st_reg.act.pin_trig) begin
            st_next.pin_pend = 1'b1; // R15
        end

        // Completion: both enabled units store, flag raised
        if (conv_end) begin
            push[0] = st_reg.act.en_one; // R2
            push[1] = st_reg.act.en_two; // R2
            st_next.busy = 1'b0; // R25
            st_next.rerun = st_reg.act.cont_run; // R4
        end

        // Immediate start aborts a running conversion; other sources wait for idle
        go = any_en && !blocked && (st_reg.imm || (!st_reg.busy && (st_reg.sh.sw_start // R1 R10
             || st_reg.pin_pend || st_reg.rerun || pin_rise // R4 R14 R15
             || (ev_compare_match && st_reg.act.cmp_trig)))); // R13 R11
        if (go) begin
            st_next.act = st_reg.sh; // R3
            st_next.busy = 1'b1; // R25
            st_next.start = 1'b1;
            st_next.sh.sw_start = 1'b0;
            st_next.imm = 1'b0;
            st_next.pin_pend = 1'b0;
            st_next.rerun = 1'b0;
        end else if (!st_reg.busy) begin
            // Idle: working copy follows the shadow, frozen once running
            st_next.act = st_reg.sh; // R3
        end
        if (st_reg.busy && !conv_end) begin
            st_next.rerun = 1'b0;
        end
        // Soft suspend finishes the current conversion, then no new start
        st_next.hold = blocked && !st_reg.susp_soft; // R12

        // Register writes, taken on the completing edge
        if (wr_now && avs_address == ADDR_CTRL_ONE) begin
            if (avs_byteenable[1]) begin
                st_next.susp_soft = avs_writedata[B_SUSP_SOFT]; // R12
                st_next.susp_free = avs_writedata[B_SUSP_FREE]; // R12
                if (avs_writedata[B_IMM_START]) begin
                    st_next.imm = 1'b1; // R1
                end
                st_next.sh.en_one = avs_writedata[B_EN_ONE]; // R2
                st_next.sh.en_two = avs_writedata[B_EN_TWO]; // R2
                st_next.sh.cont_run = avs_writedata[B_CONT_RUN]; // R4
                st_next.sh.irq_en = avs_writedata[B_IRQ_EN]; // R5
                flag_clr = avs_writedata[B_IRQ_FLAG]; // R6
            end
            if (avs_byteenable[0]) begin
                st_next.sh.sel_two = avs_writedata[B_SEL_TWO +: 3]; // R8
                st_next.sh.sel_one = avs_writedata[B_SEL_ONE +: 3]; // R9
                if (avs_writedata[B_SW_START]) begin
                    st_next.sh.sw_start = 1'b1; // R10
                end
            end
        end
        if (wr_now && avs_address == ADDR_CTRL_TWO) begin
            // Only implemented fields are stored; reserved bits have no storage
            if (avs_byteenable[1]) begin
                st_next.sh.cmp_trig = avs_writedata[B_CMP_TRIG]; // R13 R16
                st_next.sh.pin_trig = avs_writedata[B_PIN_TRIG]; // R14 R16
            end
            if (avs_byteenable[0]) begin
                st_next.div_code = avs_writedata[B_DIVIDER +: 3]; // R20
            end
        end

        // Set wins over a clear in the same cycle
        st_next.flag = (st_reg.flag && !flag_clr) || conv_end; // R6 R23
        st_next.irq = st_reg.flag && st_reg.act.irq_en; // R5

        st_next.fifo[0] = fifo_step(st_reg.fifo[0], push[0], pop[0], unit_one_data); // R19
        st_next.fifo[1] = fifo_step(st_reg.fifo[1], push[1], pop[1], unit_two_data); // R19
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            st_reg <= '0;
            st_reg.wreq <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cif.start = st_reg.start;
    assign cif.hold = st_reg.hold;
    assign cif.div_code = st_reg.div_code; // R20

    assign avs_readdata = st_reg.rdata;
    assign avs_waitrequest = st_reg.wreq;
    assign irq_request = st_reg.irq;
    assign unit_one_input_select = st_reg.act.sel_one; // R9
    assign unit_two_input_select = st_reg.act.sel_two; // R8
    assign unit_one_active = st_reg.act.en_one;
    assign unit_two_active = st_reg.act.en_two;
    assign unit_sampling = cif.sampling;

    sequence s_conv_end;
        st_reg.busy && cif.done;
    endsequence

    sequence s_flag_write;
        avs_write && !st_reg.wreq && avs_address == ADDR_CTRL_ONE && avs_byteenable[1]
            && avs_writedata[B_IRQ_FLAG];
    endsequence

    AST_FLAG_ON_END: assert property (@(posedge mclk) disable iff (!nrst) // R23
        s_conv_end |=> st_reg.flag ##1 irq_request == $past(st_reg.act.irq_en))
        else $error("completion did not raise flag");

    AST_FLAG_CLEAR: assert property (@(posedge mclk) disable iff (!nrst) // R6
        (s_flag_write and !(st_reg.busy && cif.done)) |=> !st_reg.flag)
        else $error("write one did not clear flag");

    AST_IRQ_GATE: assert property (@(posedge mclk) disable iff (!nrst) // R5
        ##1 irq_request == $past(st_reg.flag && st_reg.act.irq_en))
        else $error("interrupt request mismatch");

    AST_START_NEEDS_UNIT: assert property (@(posedge mclk) disable iff (!nrst) // R11
        cif.start |-> (unit_one_active || unit_two_active) && st_reg.busy)
        else $error("start with no unit enabled");

    AST_SUSPEND_NO_START: assert property (@(posedge mclk) disable iff (!nrst) // R12
        (emu_suspend && !st_reg.susp_free) |=> !cif.start)
        else $error("start while suspended");

    AST_QUEUE_DEPTH: assert property (@(posedge mclk) disable iff (!nrst) // R19
        st_reg.fifo[0].lost |-> st_reg.fifo[0].count == FIFO_DEPTH)
        else $error("lost set below full depth");

    AST_RESULT_ALIGN: assert property (@(posedge mclk) disable iff (!nrst) // R21
        (rd_now && avs_address == ADDR_RESULT_ONE && st_reg.fifo[0].count != 2'h0)
        |=> avs_readdata[B_RESULT +: RES_W] == $past(st_reg.fifo[0].data[0]) && avs_readdata[5:0] == 6'h00)
        else $error("result word misaligned");

    AST_BUS_ANSWER: assert property (@(posedge mclk) disable iff (!nrst)
        ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not in one wait state");

    AST_BUSY_UNTIL_END: assert property (@(posedge mclk) disable iff (!nrst) // R25
        (cif.start ##1 !cif.done) |-> st_reg.busy)
        else $error("busy dropped before completion");

endmodule : dadc_ctrl

// ==== verilog/dadc_pkg.sv ====
package dadc_pkg;

    // Printed register indices; the bus sees each as one word at index times four
    localparam logic [15:0] IDX_CTRL_ONE = 16'h7032;
    localparam logic [15:0] IDX_CTRL_TWO = 16'h7034;
    localparam logic [15:0] IDX_RESULT_ONE = 16'h7036;
    localparam logic [15:0] IDX_RESULT_TWO = 16'h7038;
    localparam int ADDR_W = 18;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE = {IDX_CTRL_ONE, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO = {IDX_CTRL_TWO, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_RESULT_ONE = {IDX_RESULT_ONE, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_RESULT_TWO = {IDX_RESULT_TWO, 2'h0};

    // Control one fields
    localparam int B_SUSP_SOFT = 15;
    localparam int B_SUSP_FREE = 14;
    localparam int B_IMM_START = 13;
    localparam int B_EN_ONE = 12;
    localparam int B_EN_TWO = 11;
    localparam int B_CONT_RUN = 10;
    localparam int B_IRQ_EN = 9;
    localparam int B_IRQ_FLAG = 8;
    localparam int B_CONV_ACT = 7;
    localparam int B_SEL_TWO = 4;
    localparam int B_SEL_ONE = 1;
    localparam int B_SW_START = 0;
    // Control two fields
    localparam int B_CMP_TRIG = 10;
    localparam int B_PIN_TRIG = 9;
    localparam int B_LVL_ONE = 6;
    localparam int B_LVL_TWO = 3;
    localparam int B_DIVIDER = 0;
    // Result word: data left aligned above this bit, zeros below
    localparam int B_RESULT = 6;

    localparam int RES_W = 10;
    localparam logic [1:0] FIFO_DEPTH = 2'h2;
    localparam logic [1:0] LVL_LOST = 2'h3;
    localparam logic [2:0] SAMPLE_TICKS = 3'h1;
    localparam logic [2:0] CONVERT_TICKS = 3'h5;
    localparam logic [2:0] TOTAL_TICKS = SAMPLE_TICKS + CONVERT_TICKS;

    typedef enum logic [1:0] {
        PH_IDLE = 2'h0,
        PH_SAMPLE = 2'h1,
        PH_CONVERT = 2'h3
    } dadc_phase_e;

    typedef struct packed {
        logic en_one;
        logic en_two;
        logic cont_run;
        logic irq_en;
        logic [2:0] sel_two;
        logic [2:0] sel_one;
        logic sw_start;
        logic cmp_trig;
        logic pin_trig;
    } dadc_cfg_s;

    typedef struct packed {
        logic [1:0][RES_W-1:0] data;
        logic [1:0] count;
        logic lost;
    } dadc_fifo_s;

    function automatic logic [5:0] divisor_of(input logic [2:0] code);
        unique case (code)
            3'h0: return 6'h04;
            3'h1: return 6'h06;
            3'h2: return 6'h08;
            3'h3: return 6'h0A;
            3'h4: return 6'h0C;
            3'h5: return 6'h10;
            3'h6: return 6'h14;
            3'h7: return 6'h20;
        endcase
    endfunction : divisor_of

    // Pop before push, so a read and a completion in one cycle both count
    function automatic dadc_fifo_s fifo_step(input dadc_fifo_s f, input logic push, input logic pop,
                                             input logic [RES_W-1:0] din);
        dadc_fifo_s o;
        o = f;
        if (pop && o.count != 2'h0) begin
            o.data[0] = o.data[1];
            o.count = o.count - 2'h1;
            o.lost = 1'b0;
        end
        if (push) begin
            if (o.count == FIFO_DEPTH) begin
                o.data[0] = o.data[1];
                o.data[1] = din;
                o.lost = 1'b1;
            end else begin
                o.data[o.count[0]] = din;
                o.count = o.count + 2'h1;
            end
        end
        return o;
    endfunction : fifo_step

    function automatic logic [1:0] fifo_level(input dadc_fifo_s f);
        return f.lost ? LVL_LOST : f.count;
    endfunction : fifo_level

endpackage : dadc_pkg
